//--- core/spi_link_if.sv
/*
   Four-wire serial link plus hold and write-protect between host and memory.
   Assumes a pulled-up data-out line when the memory does not drive it.
*/
`timescale 1ns/1ps
interface spi_link_if;
   logic cs_n;
   logic sck;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic hold_n;
   logic wp_n;
   wire  miso_line;

   assign miso_line = miso_oe ? miso : 1'b1;

   modport memory (
      input  cs_n,
      input  sck,
      input  mosi,
      input  hold_n,
      input  wp_n,
      output miso,
      output miso_oe
   );

   modport host (
      output cs_n,
      output sck,
      output mosi,
      output hold_n,
      output wp_n,
      input  miso_line
   );
endinterface

//--- core/spi_mem_device.sv
/*
   Serial nonvolatile memory device end: op-code decode, status register,
   auto-incrementing reads and block-protected writes, hold pause.
   Assumes link pins are asynchronous to aclk and sck is far slower than aclk.
*/
`timescale 1ns/1ps
`include "spi_mem_params.svh"
module spi_mem_device #(
   parameter int AW = `MEM_ADDR_BITS
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   spi_link_if.memory             link,
   output      logic [7:0]        status_out
);
   import spi_mem_pkg::*;

   localparam int DEPTH = 2 ** AW;

   // ----------------------------------------
   // Pin synchronisers and edge detect
   // ----------------------------------------
   logic [4:0]    pin_meta;
   logic [4:0]    pin_sync;
   logic          sck_d;
   logic          cs_d;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_meta <= `SYNC_RESET;
         pin_sync <= `SYNC_RESET;
         sck_d    <= 1'b0;
         cs_d     <= 1'b1;
      end else begin
         pin_meta <= {link.cs_n, link.sck, link.mosi, link.hold_n, link.wp_n};
         pin_sync <= pin_meta;
         sck_d    <= pin_sync[3];
         cs_d     <= pin_sync[4];
      end
   end

   wire cs_s   = pin_sync[4];
   wire sck_s  = pin_sync[3];
   wire si_s   = pin_sync[2];
   wire hold_s = pin_sync[1];
   wire wp_s   = pin_sync[0];

   wire selected = ~cs_s;
   wire running  = selected & hold_s;
   wire rise     = running & sck_s & ~sck_d;
   wire fall     = running & ~sck_s & sck_d;
   wire cs_rise  = cs_s & ~cs_d;

   // ----------------------------------------
   // Core state
   // ----------------------------------------
   dev_state_t    state;
   logic [3:0]    cnt;
   logic [15:0]   sh;
   logic [AW-1:0] addr;
   logic          is_read;
   logic          wr_seen;
   logic          write_enable_latch;
   logic          spe;
   logic [2:0]    spare;
   logic [1:0]    bp;
   logic [7:0]    tx;
   logic          so_bit;
   logic          so_en;
   logic [7:0]    mem [DEPTH];

   wire [15:0]   next_sh   = {sh[14:0], si_s};
   wire [7:0]    next_byte = next_sh[7:0];
   wire [AW-1:0] next_addr = next_sh[AW-1:0];
   wire [AW-1:0] addr_inc  = addr + 1'b1;
   wire          byte_end  = rise & (cnt[2:0] == 3'd7);
   wire          addr_end  = rise & (cnt == 4'd15);
   wire          op_end    = byte_end & (state == ST_OPCODE);

   wire [7:0] status_word = {spe, spare, bp, write_enable_latch, 1'b0};

   // ----------------------------------------
   // Protection decode
   // ----------------------------------------
   wire blk_quarter = addr[AW-1] & addr[AW-2];
   wire blocked     = (bp == 2'b11) | ((bp == 2'b10) & addr[AW-1])
                    | ((bp == 2'b01) & blk_quarter);
   wire mem_wr_ok   = write_enable_latch & ~blocked;
   wire stat_wr_ok  = write_enable_latch & ~(spe & ~wp_s);
   wire mem_we      = byte_end & (state == ST_WDATA) & mem_wr_ok;
   wire stat_we     = byte_end & (state == ST_SWRITE) & stat_wr_ok;

   // ----------------------------------------
   // Op-code decode
   // ----------------------------------------
   wire op_set   = op_end & (next_byte == `OP_SET_LATCH_CMD);
   wire op_clr   = op_end & (next_byte == `OP_CLEAR_LATCH_CMD);
   wire op_sread = op_end & (next_byte == `OP_STATUS_READ_CMD);
   wire op_swr   = op_end & (next_byte == `OP_STATUS_WRITE_CMD);
   wire op_read  = op_end & (next_byte == `OP_MEM_READ);
   wire op_write = op_end & (next_byte == `OP_MEM_WRITE);

   wire reading  = (state == ST_RDATA) | (state == ST_SREAD);

   // ----------------------------------------
   // Command sequencer
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || cs_s) begin
         state   <= ST_OPCODE;
         cnt     <= 4'd0;
         sh      <= 16'h0000;
         is_read <= 1'b0;
      end else if (rise) begin
         cnt <= cnt + 4'd1;
         sh  <= next_sh;
         case (state)
            ST_OPCODE: begin
               if (op_end) begin
                  cnt <= 4'd0;
                  if (op_sread) begin
                     state <= ST_SREAD;
                  end else if (op_swr) begin
                     state <= ST_SWRITE;
                  end else if (op_read || op_write) begin
                     state   <= ST_ADDRESS;
                     is_read <= op_read;
                  end else begin
                     state <= ST_IGNORE;
                  end
               end
            end
            ST_ADDRESS: begin
               if (addr_end) begin
                  cnt   <= 4'd0;
                  state <= is_read ? ST_RDATA : ST_WDATA;
               end
            end
            ST_SWRITE: begin
               if (byte_end) begin
                  state <= ST_IGNORE;
               end
            end
            ST_RDATA, ST_WDATA, ST_SREAD, ST_IGNORE: begin
               cnt[3] <= 1'b0;
            end
            default: begin
               state <= ST_IGNORE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Address pointer
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         addr <= '0;
      end else if (addr_end && state == ST_ADDRESS) begin
         addr <= next_addr;
      end else if (byte_end && (state == ST_RDATA || state == ST_WDATA)) begin
         addr <= addr_inc;
      end
   end

   // ----------------------------------------
   // Latch and status bits
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         write_enable_latch     <= 1'b0;
         wr_seen <= 1'b0;
         {spe, spare, bp} <= `ST_STORE_RESET;
      end else if (cs_s) begin
         wr_seen <= 1'b0;
         if (cs_rise && wr_seen) begin
            write_enable_latch <= 1'b0;
         end
      end else begin
         if (op_set) begin
            write_enable_latch <= 1'b1;
         end else if (op_clr) begin
            write_enable_latch <= 1'b0;
         end
         if (op_swr || op_write) begin
            wr_seen <= 1'b1;
         end
         if (stat_we) begin
            spe   <= next_byte[`ST_PROTECT_ENABLE_BIT];
            spare <= next_byte[`ST_SPARE_HI:`ST_SPARE_LO];
            bp    <= next_byte[`ST_BLOCK_HI_BIT:`ST_BLOCK_LO_BIT];
         end
      end
   end

   // ----------------------------------------
   // Array storage
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         mem[addr] <= next_byte;
      end
   end

   // ----------------------------------------
   // Output shifter
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx     <= 8'h00;
         so_bit <= 1'b0;
      end else if (op_sread || (byte_end && state == ST_SREAD)) begin
         tx <= status_word;
      end else if (addr_end && state == ST_ADDRESS && is_read) begin
         tx <= mem[next_addr];
      end else if (byte_end && state == ST_RDATA) begin
         tx <= mem[addr_inc];
      end else if (fall && reading) begin
         so_bit <= tx[7];
         tx     <= {tx[6:0], 1'b0};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         so_en      <= 1'b0;
         status_out <= 8'h00;
      end else begin
         so_en      <= running & reading;
         status_out <= status_word;
      end
   end

   assign link.miso    = so_bit;
   assign link.miso_oe = so_en;

endmodule // spi_mem_device

//--- core/spi_mem_host.sv
/*
   Serial link host controller with an AXI4-Lite register slave: sends one
   byte per data-register write, shifting in the reply, with hold and
   write-protect levels from the control register.
   Assumes one outstanding write and one outstanding read from the master.
*/
`timescale 1ns/1ps
`include "spi_mem_params.svh"
module spi_mem_host #(
   parameter int HALF_CYCLES = `HALF_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   spi_link_if.host         link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import spi_mem_pkg::*;

   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_held;
   logic        w_held;
   logic [2:0]  ctrl;
   logic        busy;
   logic        end_frame;
   logic [7:0]  sh;
   logic [7:0]  rx;
   logic [3:0]  half;
   logic [7:0]  div;
   logic        cs_n;
   logic        sck;
   logic        mosi;
   logic        so_meta;
   logic        so_s;
   logic        hold_n;

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   wire do_write = aw_held & w_held & ~s_axi_bvalid;
   wire wr_data  = do_write & (aw_addr == `HOST_DATA_OFF) & w_strb[0];
   wire wr_ctrl  = do_write & (aw_addr == `HOST_CTRL_OFF) & w_strb[0];
   wire wr_known = (aw_addr == `HOST_DATA_OFF) | (aw_addr == `HOST_CTRL_OFF)
                 | (aw_addr == `HOST_STAT_OFF);
   wire start    = wr_data & ~busy;
   wire idle     = ~busy & cs_n;
   // Hold freezes the clock from the very edge that writes it
   wire hold_req = ctrl[`CTRL_HOLD_BIT] | (wr_ctrl & w_data[`CTRL_HOLD_BIT]);
   wire tick     = busy & ~hold_req & (div == 8'(HALF_CYCLES - 1));
   wire ar_take  = s_axi_arvalid & s_axi_arready;
   wire rd_data  = s_axi_araddr == `HOST_DATA_OFF;
   wire rd_ctrl  = s_axi_araddr == `HOST_CTRL_OFF;
   wire rd_stat  = s_axi_araddr == `HOST_STAT_OFF;
   wire [31:0] rd_word = rd_data ? {24'h00_0000, rx}
                       : rd_ctrl ? {29'h0000_0000, ctrl}
                       : {30'h0000_0000, ~cs_n, busy};
   // Mode and protect level change only between frames
   wire [2:0] ctrl_mask = idle ? 3'h7 : 3'h4;
   wire [2:0] next_ctrl = (w_data[2:0] & ctrl_mask) | (ctrl & ~ctrl_mask);

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (ar_take) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= (rd_data | rd_ctrl | rd_stat) ? rd_word : 32'h0000_0000;
         s_axi_rresp   <= (rd_data | rd_ctrl | rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Link engine
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         so_meta <= 1'b1;
         so_s    <= 1'b1;
      end else begin
         so_meta <= link.miso_line;
         so_s    <= so_meta;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl      <= `CTRL_RESET;
         busy      <= 1'b0;
         end_frame <= 1'b0;
         sh        <= 8'h00;
         rx        <= 8'h00;
         half      <= 4'd0;
         div       <= 8'h00;
         cs_n      <= 1'b1;
         sck       <= 1'b0;
         mosi      <= 1'b0;
         hold_n    <= 1'b1;
      end else begin
         if (wr_ctrl) begin
            ctrl <= next_ctrl;
         end
         hold_n <= ~ctrl[`CTRL_HOLD_BIT];
         if (idle) begin
            sck <= ctrl[`CTRL_MODE3_BIT];
         end
         if (start) begin
            busy      <= 1'b1;
            end_frame <= w_data[`DATA_END_BIT];
            sh        <= w_data[7:0];
            mosi      <= w_data[7];
            cs_n      <= 1'b0;
            sck       <= 1'b0;
            half      <= 4'd0;
            div       <= 8'h00;
         end else if (busy && hold_req) begin
            // Extra half period after hold so the memory output returns first
            div <= 8'(0 - HALF_CYCLES);
         end else if (busy) begin
            div <= tick ? 8'h00 : div + 8'h01;
            if (tick) begin
               half <= half + 4'd1;
               if (!half[0]) begin
                  sck <= 1'b1;
               end else begin
                  rx <= {rx[6:0], so_s};
                  if (half == 4'd15) begin
                     busy <= 1'b0;
                     cs_n <= end_frame;
                     sck  <= ctrl[`CTRL_MODE3_BIT];
                  end else begin
                     sck  <= 1'b0;
                     sh   <= {sh[6:0], 1'b0};
                     mosi <= sh[6];
                  end
               end
            end
         end
      end
   end

   assign link.cs_n   = cs_n;
   assign link.sck    = sck;
   assign link.mosi   = mosi;
   assign link.hold_n = hold_n;
   assign link.wp_n   = ctrl[`CTRL_WP_BIT];

endmodule // spi_mem_host

//--- core/spi_mem_params.svh
/*
   Constants for the serial memory device end and its host controller:
   op-codes, status layout, host register map, reset values and timing.
   Assumes inclusion by bare name from the device and host core files.
*/
// Functional notes
// - Chip select high: standby, output floats
// - Sample input on rise, launch on fall
// - Works in serial modes 0 and 3
// - Eight-bit op-code first; partial ignored
// - Codes: 06 set, 04 clear, 05 status read
// - Codes: 01 status write, 03 read, 02 write
// - Writes need latch set beforehand
// - Latch cleared: power-on, clear, write end
// - Status: bit7 enable, 6-4 spare, 3-2 protect
// - Status write ignores bits 1 and 0
// - Status read repeats byte every eight clocks
// - Status write: op-code plus one byte
// - Host keeps protect pin steady
// - Read: 16-bit address, top two ignored
// - Read auto-increments and wraps to zero
// - Write commits each byte, increments, wraps
// - Block protect: none, quarter, half, all
// - Latch, enable bit and pin gate status writes
// - Hold pauses command; output floats
// - Hold released at same clock level
// - Chip select rise in hold aborts
// - Host keeps chip select low in hold
`ifndef SPI_MEM_PARAMS_SVH
`define SPI_MEM_PARAMS_SVH

// ----------------------------------------
// Op-codes
// ----------------------------------------
`define OP_SET_LATCH_CMD     8'h06
`define OP_CLEAR_LATCH_CMD   8'h04
`define OP_STATUS_READ_CMD   8'h05
`define OP_STATUS_WRITE_CMD  8'h01
`define OP_MEM_READ          8'h03
`define OP_MEM_WRITE         8'h02

// ----------------------------------------
// Status register layout
// ----------------------------------------
`define ST_PROTECT_ENABLE_BIT 7
`define ST_SPARE_HI           6
`define ST_SPARE_LO           4
`define ST_BLOCK_HI_BIT       3
`define ST_BLOCK_LO_BIT       2
`define ST_LATCH_BIT          1
`define ST_STORE_RESET        6'h00
`define MEM_ADDR_BITS         14

// ----------------------------------------
// Host registers
// ----------------------------------------
`define HOST_DATA_OFF   8'h00
`define HOST_CTRL_OFF   8'h04
`define HOST_STAT_OFF   8'h08
`define DATA_END_BIT    8
`define CTRL_MODE3_BIT  0
`define CTRL_WP_BIT     1
`define CTRL_HOLD_BIT   2
`define CTRL_RESET      3'h2
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define SYNC_RESET      5'h13

// ----------------------------------------
// Timing
// ----------------------------------------
`define ACLK_PERIOD_NS  25
`define LINK_PERIOD_NS  200
`define HALF_CYCLES     ((`LINK_PERIOD_NS / 2) / `ACLK_PERIOD_NS)

`endif

//--- core/spi_mem_pkg.sv
/*
   Types shared by the serial memory ends.
   Assumes nothing beyond the compile order.
*/
package spi_mem_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE  = 3'b000,
      ST_ADDRESS = 3'b001,
      ST_RDATA   = 3'b011,
      ST_WDATA   = 3'b010,
      ST_SREAD   = 3'b110,
      ST_SWRITE  = 3'b111,
      ST_IGNORE  = 3'b101
   } dev_state_t;
endpackage

//--- tb/spi_nonvolatile_memory_slave_chk.sv
/*
   Link checker for the memory and host ends.
   Assumes plain link signals and the memory status byte as inputs.
*/
`timescale 1ns/1ps
module spi_nonvolatile_memory_slave_chk (
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       cs_n,
   input wire logic       sck,
   input wire logic       mosi,
   input wire logic       miso_oe,
   input wire logic       hold_n,
   input wire logic       wp_n,
   input wire logic [7:0] status_out
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_desel_float;
      cs_n [*4] |-> !miso_oe;
   endproperty
   a_desel_float: assert property (p_desel_float) else $error("miso driven deselected");
   property p_desel_status;
      cs_n [*8] |-> $stable(status_out);
   endproperty
   a_desel_status: assert property (p_desel_status) else $error("status moved idle");
   property p_hold_float;
      (!hold_n) [*5] |-> !miso_oe;
   endproperty
   a_hold_float: assert property (p_hold_float) else $error("miso driven in hold");
   property p_hold_freeze;
      !hold_n |-> $stable(sck) && $stable(cs_n);
   endproperty
   a_hold_freeze: assert property (p_hold_freeze) else $error("hold moved");
   property p_bit0_zero;
      status_out[0] == 1'b0;
   endproperty
   a_bit0_zero: assert property (p_bit0_zero) else $error("status bit 0 set");
   property p_mosi_hold;
      !cs_n && sck && $past(sck) |-> $stable(mosi);
   endproperty
   a_mosi_hold: assert property (p_mosi_hold) else $error("mosi moved while sck high");
   property p_wp_frame;
      $changed(wp_n) |-> $past(cs_n);
   endproperty
   a_wp_frame: assert property (p_wp_frame) else $error("wp changed in frame");
   property p_latch_frame;
      $rose(status_out[1]) |-> !$past(cs_n, 6);
   endproperty
   a_latch_frame: assert property (p_latch_frame) else $error("latch set outside frame");
   c_read: cover property (miso_oe);
   c_hold: cover property (!hold_n && !cs_n);
   c_latch: cover property ($rose(status_out[1]));
endmodule // spi_nonvolatile_memory_slave_chk

//--- tb/tb_spi_nonvolatile_memory_slave.sv
/*
   Bench: AXI4-Lite master drives the host; host and memory meet on the link.
   Assumes the host register map and timing of the shared header.
*/
`timescale 1ns/1ps
`include "spi_mem_params.svh"
module tb_spi_nonvolatile_memory_slave;
   logic        aclk = 0;
   logic        aresetn = 0;
   logic [7:0]  awaddr = 0;
   logic [7:0]  araddr = 0;
   logic [31:0] wdata = 0;
   logic        awvalid = 0;
   logic        wvalid = 0;
   logic        bready = 0;
   logic        arvalid = 0;
   logic        rready = 0;
   wire  [1:0]  bresp;
   wire  [1:0]  rresp;
   wire  [31:0] rdata;
   wire         awready, wready, bvalid, arready, rvalid;
   wire  [7:0]  status_out;
   logic [31:0] seed = 32'h0000_F54B;
   logic [7:0]  rx, rx2, d0, d1, m_hi, m_lo;
   logic [31:0] d;
   logic [1:0]  r;
   int          err_count = 0;
   int          check_count = 0;
   spi_link_if link ();
   spi_mem_device spi_mem_device_inst (.aclk(aclk), .aresetn(aresetn), .link(link),
      .status_out(status_out));
   spi_mem_host #(.HALF_CYCLES(4)) spi_mem_host_inst (.aclk(aclk), .aresetn(aresetn),
      .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   spi_nonvolatile_memory_slave_chk spi_nonvolatile_memory_slave_chk_inst (.aclk(aclk),
      .aresetn(aresetn), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
      .miso_oe(link.miso_oe), .hold_n(link.hold_n), .wp_n(link.wp_n), .status_out(status_out));
   always #12.5 aclk = ~aclk;
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   task automatic start(input logic [7:0] b, input logic last);
      wr(`HOST_DATA_OFF, {23'h00_0000, last, b}, r);
   endtask
   task automatic finish(output logic [7:0] q);
      do begin
         rd(`HOST_STAT_OFF, d, r);
      end while (d[0] !== 1'b0);
      rd(`HOST_DATA_OFF, d, r);
      q = d[7:0];
      repeat (6) @(posedge aclk);
   endtask
   task automatic xfer(input logic [7:0] b, input logic last, output logic [7:0] q);
      start(b, last);
      finish(q);
   endtask
   task automatic status_write_cmd(input logic [7:0] v, input logic en);
      if (en) xfer(`OP_SET_LATCH_CMD, 1'b1, rx);
      xfer(`OP_STATUS_WRITE_CMD, 1'b0, rx);
      xfer(v, 1'b1, rx);
   endtask
   task automatic addr_cmd(input logic [7:0] op, input logic [15:0] a);
      xfer(op, 1'b0, rx);
      xfer(a[15:8], 1'b0, rx);
      xfer(a[7:0], 1'b0, rx);
   endtask
   task automatic mem_wr(input logic [15:0] a, input logic [7:0] x, y, input logic en);
      if (en) xfer(`OP_SET_LATCH_CMD, 1'b1, rx);
      addr_cmd(`OP_MEM_WRITE, a);
      xfer(x, 1'b0, rx);
      xfer(y, 1'b1, rx);
   endtask
   task automatic mem_rd(input logic [15:0] a);
      addr_cmd(`OP_MEM_READ, a);
      xfer(xs(), 1'b0, rx);
      xfer(xs(), 1'b1, rx2);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge aclk);
      err_count++;
      end_sim;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("status_rst", 8'h00, status_out);
      rd(8'h40, d, r);
      chk("rresp", {6'h00, `RESP_SLVERR}, {6'h00, r});
      wr(8'h40, 32'h0000_0000, r);
      chk("bresp", {6'h00, `RESP_SLVERR}, {6'h00, r});
      xfer(`OP_SET_LATCH_CMD, 1'b1, rx);
      chk("latch_set", 8'h02, status_out);
      xfer(`OP_CLEAR_LATCH_CMD, 1'b1, rx);
      chk("latch_clr", 8'h00, status_out);
      xfer(8'h55, 1'b0, rx);
      xfer(xs(), 1'b1, rx);
      chk("unknown_rx", 8'hFF, rx);
      status_write_cmd(8'hFF, 1'b0);
      chk("status_write_cmd_nolatch", 8'h00, status_out);
      status_write_cmd(8'hFF, 1'b1);
      chk("status_write_cmd", 8'hFC, status_out);
      xfer(`OP_STATUS_READ_CMD, 1'b0, rx);
      xfer(xs(), 1'b0, rx);
      chk("rdsr0", 8'hFC, rx);
      xfer(xs(), 1'b1, rx);
      chk("rdsr1", 8'hFC, rx);
      wr(`HOST_CTRL_OFF, 32'h0000_0000, r);
      status_write_cmd(8'h00, 1'b1);
      chk("status_write_cmd_wp", 8'hFC, status_out);
      wr(`HOST_CTRL_OFF, 32'h0000_0002, r);
      status_write_cmd(8'h00, 1'b1);
      chk("status_write_cmd_ok", 8'h00, status_out);
      for (int bp = 0; bp < 4; bp++) begin
         wr(`HOST_CTRL_OFF, {30'h0000_0000, 1'b1, bp[0]}, r);
         status_write_cmd({4'h0, bp[1:0], 2'h0}, 1'b1);
         d0 = xs();
         d1 = xs();
         mem_wr(16'hFFFF, d0, d1, 1'b1);
         if (bp == 0) m_hi = d0;
         if (bp != 3) m_lo = d1;
         mem_rd(16'hFFFF);
         chk("mem_hi", m_hi, rx);
         chk("mem_lo", m_lo, rx2);
      end
      status_write_cmd(8'h00, 1'b1);
      mem_wr(16'h3FFF, ~m_hi, ~m_lo, 1'b0);
      mem_rd(16'h3FFF);
      chk("mem_nolatch", m_hi, rx);
      addr_cmd(`OP_MEM_READ, 16'h3FFF);
      start(xs(), 1'b0);
      wr(`HOST_CTRL_OFF, 32'h0000_0004, r);
      chk("bresp_ok", {6'h00, `RESP_OKAY}, {6'h00, r});
      rd(`HOST_CTRL_OFF, d, r);
      chk("ctrl_busy", 8'h07, d[7:0]);
      rd(`HOST_STAT_OFF, d, r);
      chk("stat_busy", 8'h03, d[7:0]);
      repeat (40) @(posedge aclk);
      wr(`HOST_CTRL_OFF, 32'h0000_0000, r);
      finish(rx);
      chk("hold_rx", m_hi, rx);
      xfer(xs(), 1'b1, rx2);
      chk("hold_next", m_lo, rx2);
      end_sim;
   end
endmodule // tb_spi_nonvolatile_memory_slave
